// ---- rtl/odt_consts.vh ----
// Constants for the oscillator-divided 8-bit match timer
`ifndef ODT_CONSTS_VH
`define ODT_CONSTS_VH

// ----------------------------------------------------------------
// Register word indices (byte address is index times 4, all word aligned)
// ----------------------------------------------------------------
`define ODT_IDX_CLKCTL   16'h5065
`define ODT_IDX_CTL      16'h50C0
`define ODT_IDX_CNT      16'h50C1
`define ODT_IDX_CMP      16'h50C2
`define ODT_IDX_IMSK     16'h50C3
`define ODT_IDX_IFLG     16'h50C4
`define ODT_ADDR_W       18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ODT_CTL_RUN      0
`define ODT_CTL_MODE     1
`define ODT_CTL_CLR      4
`define ODT_CLK_EN       0
`define ODT_CLK_DIV_LO   1
`define ODT_CLK_DIV_HI   3
`define ODT_IRQ_MATCH    0

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define ODT_RST_BYTE     8'h00
`define ODT_RST_DIV      3'h0
`define ODT_DIV_MAX      3'h5
`define ODT_PRE_W        5

`endif

// ---- rtl/odt_divider.v ----
// Low-speed oscillator divider giving one-cycle count ticks
`timescale 1ns/1ns
`include "odt_consts.vh"

module odt_divider
(
  input  wire       clk_i,
  input  wire       arst_n_i,
  input  wire       ce_i,
  input  wire       osc_tick_i,
  input  wire [2:0] div_sel_i,
  input  wire       gate_i,
  output reg        tick_o
);

  reg  [`ODT_PRE_W-1:0] pre_r;
  wire [`ODT_PRE_W-1:0] pre_nxt;
  wire [`ODT_PRE_W-1:0] mask;

  // Ratio 2^sel for sel 0..5, sel above 5 gives 1; each oscillator tick advances the prescaler
  assign mask    = (div_sel_i > `ODT_DIV_MAX) ? {`ODT_PRE_W{1'b0}}
                   : ((5'h01 << div_sel_i) - 5'h01);
  assign pre_nxt = pre_r + 5'h01;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pre_r  <= {`ODT_PRE_W{1'b0}};
      tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      tick_o <= 1'b0;
      if (osc_tick_i)
      begin
        pre_r <= pre_nxt;
        // Gate blocks the tick, prescaler keeps running
        tick_o <= gate_i && ((pre_r & mask) == mask);
      end
    end
  end

endmodule // odt_divider

// ---- rtl/odt_timer.v ----
// Oscillator-divided 8-bit match timer with Wishbone registers
`timescale 1ns/1ns
`include "odt_consts.vh"

module odt_timer
(
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire        ce_i,
  input  wire        osc_tick_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  output reg         irq_o
);

  // ----------------------------------------------------------------
  // Register address decode
  // ----------------------------------------------------------------
  function [2:0] reg_sel;
    input [31:0] adr;
    begin
      if (adr[1:0] != 2'b00 || adr[31:`ODT_ADDR_W] != 0)
        reg_sel = 3'd7;
      else if (adr[`ODT_ADDR_W-1:2] == `ODT_IDX_CLKCTL)
        reg_sel = 3'd0;
      else if (adr[`ODT_ADDR_W-1:2] == `ODT_IDX_CTL)
        reg_sel = 3'd1;
      else if (adr[`ODT_ADDR_W-1:2] == `ODT_IDX_CNT)
        reg_sel = 3'd2;
      else if (adr[`ODT_ADDR_W-1:2] == `ODT_IDX_CMP)
        reg_sel = 3'd3;
      else if (adr[`ODT_ADDR_W-1:2] == `ODT_IDX_IMSK)
        reg_sel = 3'd4;
      else if (adr[`ODT_ADDR_W-1:2] == `ODT_IDX_IFLG)
        reg_sel = 3'd5;
      else
        reg_sel = 3'd7;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg        clk_en_r;
  reg  [2:0] div_sel_r;
  reg        run_r;
  reg        mode_r;
  reg  [7:0] cnt_r;
  reg  [7:0] cnt_nxt;
  reg  [7:0] cmp_r;
  reg        ie_r;
  reg        flag_r;
  reg        run_nxt;
  reg        flag_nxt;
  wire       tick;
  wire       req;
  wire [2:0] sel;
  wire       wr;
  wire       lane0;
  wire       match;

  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign sel   = reg_sel(wb_adr_i);
  assign lane0 = wb_sel_i[0];
  assign wr    = req && wb_we_i && lane0 && (sel != 3'd7);

  odt_divider u_div
  (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .osc_tick_i (osc_tick_i),
    .div_sel_i  (div_sel_r),
    .gate_i     (clk_en_r),
    .tick_o     (tick)
  );

  // ----------------------------------------------------------------
  // Counter and match
  // ----------------------------------------------------------------
  // A match only counts while running and on a tick, so a stopped
  // counter sitting on the match value raises nothing.
  assign match = run_r && tick && (cnt_r == cmp_r);

  always @*
  begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    flag_nxt = flag_r;
    if (match)
    begin
      cnt_nxt = 8'h00;
      if (mode_r)
        run_nxt = 1'b0;
    end
    else if (run_r && tick)
      cnt_nxt = cnt_r + 8'h01;
    if (wr && sel == 3'd1)
    begin
      if (wb_dat_i[`ODT_CTL_CLR])
        cnt_nxt = 8'h00;
      run_nxt = wb_dat_i[`ODT_CTL_RUN];
    end
    // Clear first, then set, so an event on the clear cycle survives
    if (wr && sel == 3'd5 && wb_dat_i[`ODT_IRQ_MATCH])
      flag_nxt = 1'b0;
    if (match && ie_r)
      flag_nxt = 1'b1;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      clk_en_r  <= 1'b0;
      div_sel_r <= `ODT_RST_DIV;
      run_r     <= 1'b0;
      mode_r    <= 1'b0;
      cnt_r     <= `ODT_RST_BYTE;
      cmp_r     <= `ODT_RST_BYTE;
      ie_r      <= 1'b0;
      flag_r    <= 1'b0;
      irq_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_r  <= cnt_nxt;
      run_r  <= run_nxt;
      flag_r <= flag_nxt;
      irq_o  <= flag_nxt;
      if (wr && sel == 3'd0)
      begin
        clk_en_r  <= wb_dat_i[`ODT_CLK_EN];
        div_sel_r <= wb_dat_i[`ODT_CLK_DIV_HI:`ODT_CLK_DIV_LO];
      end
      if (wr && sel == 3'd1)
        mode_r <= wb_dat_i[`ODT_CTL_MODE];
      if (wr && sel == 3'd3)
        cmp_r <= wb_dat_i[7:0];
      if (wr && sel == 3'd4)
        ie_r <= wb_dat_i[`ODT_IRQ_MATCH];
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------
  // One wait state: ack registered in the cycle after the request.
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= req && (sel != 3'd7);
      wb_err_o <= req && (sel == 3'd7);
      wb_dat_o <= 32'h00000000;
      if (req && !wb_we_i)
      begin
        case (sel)
          3'd0:    wb_dat_o[3:0] <= {div_sel_r, clk_en_r};
          3'd1:    wb_dat_o[1:0] <= {mode_r, run_r};
          3'd2:    wb_dat_o[7:0] <= cnt_r;
          3'd3:    wb_dat_o[7:0] <= cmp_r;
          3'd4:    wb_dat_o[0]   <= ie_r;
          3'd5:    wb_dat_o[0]   <= flag_r;
          default: wb_dat_o      <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // odt_timer

// ---- verif/odt_checker.sv ----
// Port assertions for the match timer
`timescale 1ns/1ns
module odt_checker(
  input wire        clk_i, arst_n_i, ce_i, osc_tick_i, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire [31:0] wb_adr_i, wb_dat_i, wb_dat_o,
  input wire [3:0]  wb_sel_i,
  input wire        wb_ack_o, wb_err_o, irq_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire tk = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o & ce_i;
  // Flag clear: write of a one to the flag register
  wire fc = tk & wb_we_i & wb_sel_i[0] & wb_dat_i[0] & (wb_adr_i == 32'h14310);
  AST_ACK_LAT: assert property (tk |=> wb_ack_o ^ wb_err_o) else $error("no answer");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  AST_NO_REQ: assert property (!(wb_cyc_i & wb_stb_i) |=> !(wb_ack_o | wb_err_o)) else $error("stray answer");
  AST_ERR: assert property (tk & |wb_adr_i[1:0] |=> wb_err_o) else $error("bad address taken");
  AST_CTL_RD: assert property (tk & !wb_we_i & wb_adr_i == 32'h14300 |=> wb_dat_o[31:4] == 28'h0) else $error("ctl read");
  AST_IRQ_SRC: assert property ($rose(irq_o) |-> $past(osc_tick_i, 2)) else $error("irq without tick");
  AST_IRQ_HOLD: assert property (irq_o & !fc |=> irq_o) else $error("irq dropped");
  AST_IRQ_CLR: assert property (fc |=> !irq_o) else $error("irq not cleared");
endmodule // odt_checker
bind odt_timer odt_checker u_chk (.*);

// ---- verif/odt_irq_model.sv ----
// Interrupt controller model counting edge requests
`timescale 1ns/1ns
module odt_irq_model(
  input wire       clk_i, arst_n_i, irq_i,
  output reg [7:0] req_cnt_o);
  reg q_r;
  // Edge trigger: one request counted per rise of irq_i, nothing held while it stays high
  always @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i) {q_r, req_cnt_o} <= 9'h000;
    else {q_r, req_cnt_o} <= {irq_i, req_cnt_o + {7'h00, irq_i & !q_r}};
endmodule // odt_irq_model

// ---- verif/testbench.sv ----
// Self-checking bench for the match timer
`timescale 1ns/1ns
module testbench;
  localparam [31:0] CK = 32'h14194, CT = 32'h14300, CN = 32'h14304, CM = 32'h14308, MK = 32'h1430C, FL = 32'h14310;
  reg clk_i = 0, arst_n_i = 0, osc_tick_i = 0, cyc = 0, we = 0, e;
  reg [31:0] adr = 0, dat = 0, v;
  wire [31:0] rd;
  wire ack, err, irq;
  wire [7:0] nreq;
  integer err_count = 0, checked = 0, i, m;
  always #4 clk_i = !clk_i;
  odt_timer dut(.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .osc_tick_i(osc_tick_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .wb_err_o(err), .irq_o(irq));
  odt_irq_model icm(.clk_i(clk_i), .arst_n_i(arst_n_i), .irq_i(irq), .req_cnt_o(nreq));
  task complete_run;
    begin
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] x, input [31:0] g);
    begin
      checked = checked + 1;
      if (x !== g) begin err_count = err_count + 1; $display("ERROR %s exp %h got %h", n, x, g); end
    end
  endtask
  // Answer is taken at the rising edge that sees ack or err, then the request drops
  task bus(input w, input [31:0] a, input [7:0] d);
    begin
      @(posedge clk_i); cyc <= 1; we <= w; adr <= a; dat <= {24'h0, d};
      do @(posedge clk_i); while (!(ack | err));
      v = rd; e = err;
      cyc <= 0; we <= 0;
    end
  endtask
  task tk(input integer n);
    begin
      repeat (n) begin @(posedge clk_i) osc_tick_i <= 1; @(posedge clk_i) osc_tick_i <= 0;
        repeat ($urandom % 3) @(posedge clk_i); end
      repeat (3) @(posedge clk_i);
    end
  endtask
  initial begin #400000; err_count = err_count + 1; complete_run; end
  initial begin
    v = $urandom(32'h681A2C00);
    repeat (10) @(posedge clk_i); arst_n_i <= 1;
    for (i = 0; i < 6; i = i + 1) begin bus(0, i ? CT + 4 * (i - 1) : CK, 0); chk("reset", 0, v); end
    bus(0, CT + 1, 0); chk("unmapped", 1, e);
    bus(1, CT, 8'h11); tk(3); bus(1, CT, 0); bus(0, CN, 0); chk("gated", 0, v);
    bus(1, CM, 8'hFF);
    for (i = 0; i < 6; i = i + 1) begin
      m = 1 + $urandom % 4; bus(1, CK, 2 * i + 1); bus(1, CT, 8'h11);
      tk(m << i); bus(1, CT, 0); bus(0, CN, 0); chk("divided", m, v);
      tk(2); bus(0, CN, 0); chk("held", m, v);
      bus(1, CT, 1); tk(1 << i); bus(1, CT, 0); bus(0, CN, 0); chk("resumed", m + 1, v);
    end
    bus(1, CK, 1); bus(1, MK, 1);
    // Mode is taken from every control write; each pass writes it with run off, then starts
    for (i = 0; i < 2; i = i + 1) begin
      m = 2 + $urandom % 5; bus(1, CM, m); bus(1, CT, 2 * i); bus(1, CT, 8'h11 + 2 * i);
      tk(m); bus(0, FL, 0); chk("early", 0, v);
      tk(1); bus(0, FL, 0); chk("flag", 1, v); chk("irq", 1, irq);
      tk(2); bus(0, CN, 0); chk("after", i ? 0 : 2, v);
      bus(0, CT, 0); chk("run", i ? 2 : 1, v);
      bus(1, CT, 2 * i); bus(1, FL, 1); chk("cleared", 0, irq); chk("requests", i + 1, nreq);
    end
    bus(1, MK, 0); bus(1, CT, 8'h11); tk(m + 1); bus(1, CT, 0);
    bus(0, FL, 0); chk("masked", 0, v); chk("no irq", 0, irq);
    bus(1, CK, 0); bus(0, CK, 0); chk("supply off", 0, v);
    complete_run;
  end
endmodule // testbench
